//--- logic/ifd_decode.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module ifd_decode #(
  parameter int ADDR_W = 8,
  parameter logic [3:0] ACCESS_BANK = 4'h0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded instruction and cycle timing
  output ifd_pkg::ifd_dec_s dec,
  output logic [1:0] quarter,
  output logic cycle_end,
  output logic nop_cycle,
  output logic busy
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_NEED2 = 3'h2,
    ST_EXEC = 3'h4
  } ifd_st_e;

  function automatic logic map_hit(input logic [15:0] map, input logic [3:0] nib);
    map_hit = map[nib];
  endfunction : map_hit

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs[ADDR_W-1:0]);
  endfunction : reg_hit

  ifd_st_e st_reg;
  ifd_pkg::ifd_dec_s dec_reg;
  ifd_pkg::ifd_dec_s dec_next;
  logic [1:0] ctrl_reg;
  logic [3:0] bank_reg;
  logic [1:0] q_reg;
  logic [1:0] left_reg;
  logic [1:0] last_cycles_reg;
  logic err_reg;
  logic [7:0] done_reg;
  logic [15:0] first_reg;
  logic cycle_end_reg;
  logic nop_cycle_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  logic access;
  logic setup_ok;
  logic wr_instr;
  logic wr_stat;
  logic [15:0] word;
  logic [3:0] nib;
  logic dw_first;
  logic second_tag;
  logic extra;
  logic addr_ok;
  logic instr_ok;
  logic [31:0] rd_val;
  logic exec_last;

  assign access = psel && penable && pready_reg;
  assign word = pwdata[15:0];
  assign nib = word[ifd_pkg::OPC_LSB +: 4];
  assign second_tag = (nib == ifd_pkg::SECOND_TAG);
  assign instr_ok = (st_reg == ST_IDLE) || (st_reg == ST_NEED2);
  assign wr_instr = access && pwrite && reg_hit(paddr, ifd_pkg::OFS_INSTR);
  assign wr_stat = access && pwrite && reg_hit(paddr, ifd_pkg::OFS_STAT);

  // First words of the four two-word instructions
  always_comb begin
    dw_first = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if ((word & ifd_pkg::DW_MASK[i]) == ifd_pkg::DW_MATCH[i]) begin
        dw_first = 1'b1;
      end
    end
  end

  // Field split of the presented word
  always_comb begin
    dec_next = dec_reg;
    if (st_reg == ST_IDLE) begin
      dec_next.opcode = nib;
      dec_next.file_addr = word[ifd_pkg::F_LSB +: 8];
      dec_next.banked = word[ifd_pkg::A_POS];
      dec_next.dest_working_register = ~word[ifd_pkg::D_POS];
      dec_next.bit_num = word[ifd_pkg::B_LSB +: 3];
      dec_next.literal = word[ifd_pkg::K_LSB +: 8];
      dec_next.pointer_load = (word & ifd_pkg::PTR_MASK) == ifd_pkg::PTR_MATCH;
      dec_next.pointer_sel = word[ifd_pkg::P_LSB +: 2];
      dec_next.prog_addr = word[ifd_pkg::N_LSB +: 8];
      dec_next.shadow = word[ifd_pkg::S_POS];
      dec_next.tbl_mode = ifd_pkg::ifd_tbl_e'(word[ifd_pkg::M_LSB +: 2]);
      dec_next.double_word = dw_first && !second_tag;
      dec_next.is_nop = second_tag || (word == ifd_pkg::NOP_WORD);
      // Fixed area ignores the bank selector
      dec_next.eff_addr = {word[ifd_pkg::A_POS] ? bank_reg : ACCESS_BANK, word[ifd_pkg::F_LSB +: 8]};
      if (map_hit(ifd_pkg::BIT_MAP, nib)) begin
        dec_next.cls = ifd_pkg::CLS_BIT;
      end else if (map_hit(ifd_pkg::LIT_MAP, nib) || dec_next.pointer_load) begin
        dec_next.cls = ifd_pkg::CLS_LIT;
      end else if (map_hit(ifd_pkg::CTL_MAP, nib) || second_tag) begin
        dec_next.cls = ifd_pkg::CLS_CTL;
      end else begin
        dec_next.cls = ifd_pkg::CLS_BYTE;
      end
    end
  end

  // Extra no-operation cycle for a true test or a program counter change
  assign extra = (map_hit(ifd_pkg::COND_MAP, nib) && ctrl_reg[ifd_pkg::CTRL_COND]) ||
                 map_hit(ifd_pkg::JUMP_MAP, nib);
  assign exec_last = (st_reg == ST_EXEC) && (q_reg == ifd_pkg::LAST_QUARTER) && (left_reg == 2'h1);

  // Read mux has no side effects, so a repeated read is harmless
  always_comb begin
    addr_ok = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      ifd_pkg::OFS_INSTR[ADDR_W-1:0]: rd_val = {16'h0000, first_reg};
      ifd_pkg::OFS_CTRL[ADDR_W-1:0]: rd_val = {30'h0000_0000, ctrl_reg};
      ifd_pkg::OFS_BANK[ADDR_W-1:0]: rd_val = {28'h000_0000, bank_reg};
      ifd_pkg::OFS_DEC0[ADDR_W-1:0]: rd_val = {dec_reg.cls,
                                               dec_reg.opcode,
                                               1'b0,
                                               dec_reg.double_word,
                                               dec_reg.is_nop,
                                               dec_reg.dest_working_register,
                                               dec_reg.banked,
                                               dec_reg.bit_num,
                                               dec_reg.file_addr,
                                               dec_reg.literal};
      ifd_pkg::OFS_DEC1[ADDR_W-1:0]: rd_val = {2'h0,
                                               dec_reg.pointer_load,
                                               dec_reg.shadow,
                                               dec_reg.tbl_mode,
                                               dec_reg.pointer_sel,
                                               dec_reg.prog_addr,
                                               4'h0,
                                               dec_reg.eff_addr};
      ifd_pkg::OFS_STAT[ADDR_W-1:0]: rd_val = {16'h0000,
                                               done_reg,
                                               1'b0,
                                               last_cycles_reg,
                                               err_reg,
                                               nop_cycle_reg,
                                               st_reg == ST_EXEC,
                                               st_reg == ST_NEED2,
                                               st_reg != ST_IDLE};
      ifd_pkg::OFS_INFO[ADDR_W-1:0]: rd_val = {16'h0000, ifd_pkg::EXT_COUNT, ifd_pkg::STD_COUNT};
      default: addr_ok = 1'b0;
    endcase
  end

  // Writes to the word register wait until the sequencer can take a word
  assign setup_ok = !(pwrite && reg_hit(paddr, ifd_pkg::OFS_INSTR) && !instr_ok);

  // APB answer, one wait state at least
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (psel && penable && !pready_reg && setup_ok) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !addr_ok;
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
  end

  // Software controls: condition outcome, extended set enable, bank selector
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_reg <= ifd_pkg::CTRL_RST;
      bank_reg <= ifd_pkg::BANK_RST;
    end else if (access && pwrite) begin
      if (reg_hit(paddr, ifd_pkg::OFS_CTRL)) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (reg_hit(paddr, ifd_pkg::OFS_BANK)) begin
        bank_reg <= pwdata[3:0];
      end
    end
  end

  // Quarter counter restarts with each accepted word so a cycle is whole
  always_ff @(posedge clock) begin
    if (!nrst) begin
      q_reg <= 2'h0;
    end else begin
      q_reg <= wr_instr ? 2'h0 : q_reg + 2'h1;
    end
  end

  // Cycle boundary pulse; a restart cancels the boundary that was due
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cycle_end_reg <= 1'b0;
    end else begin
      cycle_end_reg <= !wr_instr && (q_reg == ifd_pkg::LAST_QUARTER);
    end
  end

  // Sequencer
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg <= ST_IDLE;
      left_reg <= 2'h0;
      last_cycles_reg <= 2'h0;
      nop_cycle_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          if (wr_instr) begin
            nop_cycle_reg <= second_tag;
            if (dw_first && !second_tag) begin
              st_reg <= ST_NEED2;
            end else begin
              st_reg <= ST_EXEC;
              left_reg <= (!second_tag && extra) ? 2'h2 : 2'h1;
              last_cycles_reg <= (!second_tag && extra) ? 2'h2 : 2'h1;
            end
          end
        end
        ST_NEED2: begin
          if (wr_instr) begin
            if (second_tag) begin
              st_reg <= ST_EXEC;
              left_reg <= 2'h2;
              last_cycles_reg <= 2'h2;
            end else begin
              st_reg <= ST_IDLE;
            end
          end
        end
        ST_EXEC: begin
          if (q_reg == ifd_pkg::LAST_QUARTER) begin
            if (left_reg == 2'h1) begin
              st_reg <= ST_IDLE;
              nop_cycle_reg <= 1'b0;
            end else begin
              left_reg <= left_reg - 2'h1;
              // Second cycle of a taken test or single-word jump carries no work
              nop_cycle_reg <= !dec_reg.double_word;
            end
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Last word taken in IDLE, read back through the word register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      first_reg <= 16'h0000;
    end else if (wr_instr && st_reg == ST_IDLE) begin
      first_reg <= word;
    end
  end

  // Retired instruction tally; wraps at 255, so software must sample it often enough
  always_ff @(posedge clock) begin
    if (!nrst) begin
      done_reg <= 8'h00;
    end else if (exec_last) begin
      done_reg <= done_reg + 8'h01;
    end
  end

  // Malformed second word flag; a new fault beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      err_reg <= 1'b0;
    end else if (st_reg == ST_NEED2 && wr_instr && !second_tag) begin
      err_reg <= 1'b1;
    end else if (wr_stat && pwdata[ifd_pkg::STAT_ERR]) begin
      err_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      dec_reg <= '0;
    end else if (wr_instr && st_reg == ST_IDLE) begin
      dec_reg <= dec_next;
    end
  end

  // Ports are plain copies of flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign dec = dec_reg;
  assign quarter = q_reg;
  assign cycle_end = cycle_end_reg;
  assign nop_cycle = nop_cycle_reg;

  // Busy also covers the first cycle after an accepted second word
  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else begin
      busy <= ((st_reg == ST_EXEC) && !exec_last) ||
              (st_reg == ST_IDLE && wr_instr) ||
              (st_reg == ST_NEED2 && wr_instr && second_tag);
    end
  end

endmodule : ifd_decode

//--- logic/ifd_pkg.sv
package ifd_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_BANK = 8'h08;
  localparam logic [7:0] OFS_DEC0 = 8'h0C;
  localparam logic [7:0] OFS_DEC1 = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_INFO = 8'h18;

  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [3:0] BANK_RST = 4'h0;

  // Instruction set size and timing
  localparam logic [7:0] STD_COUNT = 8'h4B;
  localparam logic [7:0] EXT_COUNT = 8'h08;
  localparam logic [1:0] LAST_QUARTER = 2'h3;
  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_PER_CYCLE = 4;
  localparam int CLK_PER_CYCLE = OSC_PER_CYCLE;

  // Field positions inside a program word
  localparam int OPC_LSB = 12;
  localparam int F_LSB = 0;
  localparam int A_POS = 8;
  localparam int D_POS = 9;
  localparam int B_LSB = 9;
  localparam int K_LSB = 0;
  localparam int P_LSB = 4;
  localparam int S_POS = 0;
  localparam int M_LSB = 0;
  localparam int N_LSB = 0;
  localparam logic [3:0] SECOND_TAG = 4'hF;

  // Control register bits and the status register clear bit
  localparam int CTRL_COND = 0;
  localparam int CTRL_EXT = 1;
  localparam int STAT_ERR = 2;

  // Class and timing maps, one bit per value of the top nibble
  localparam logic [15:0] BIT_MAP = 16'h0F80;
  localparam logic [15:0] LIT_MAP = 16'h0001;
  localparam logic [15:0] CTL_MAP = 16'h7000;
  localparam logic [15:0] COND_MAP = 16'h0C00;
  localparam logic [15:0] JUMP_MAP = 16'h7000;

  // Double-word first words and the pointer-load form
  localparam logic [3:0][15:0] DW_MASK = {16'hF000, 16'hFE00, 16'hFF00, 16'hFFC0};
  localparam logic [3:0][15:0] DW_MATCH = {16'hC000, 16'hEC00, 16'hEF00, 16'hEE00};
  localparam logic [15:0] PTR_MASK = 16'hFFC0;
  localparam logic [15:0] PTR_MATCH = 16'hEE00;
  localparam logic [15:0] NOP_WORD = 16'h0000;

  typedef enum logic [3:0] {
    CLS_BYTE = 4'h1,
    CLS_BIT = 4'h2,
    CLS_LIT = 4'h4,
    CLS_CTL = 4'h8
  } ifd_cls_e;

  typedef enum logic [1:0] {
    TBL_NONE = 2'h0,
    TBL_POSTINC = 2'h1,
    TBL_POSTDEC = 2'h2,
    TBL_PREINC = 2'h3
  } ifd_tbl_e;

  typedef struct packed {
    ifd_cls_e cls;
    logic [3:0] opcode;
    logic [7:0] file_addr;
    logic dest_working_register;
    logic banked;
    logic [11:0] eff_addr;
    logic [2:0] bit_num;
    logic [7:0] literal;
    logic [1:0] pointer_sel;
    logic pointer_load;
    logic [7:0] prog_addr;
    logic shadow;
    ifd_tbl_e tbl_mode;
    logic double_word;
    logic is_nop;
  } ifd_dec_s;

endpackage : ifd_pkg

//--- verif/ifd_decode_assertions.sv
`timescale 1ns/1ps
module ifd_decode_checker #(
  parameter int ADDR_W = 8,
  parameter logic [3:0] ACCESS_BANK = 4'h0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Decode and timing
  input wire ifd_pkg::ifd_dec_s dec,
  input wire logic [1:0] quarter,
  input wire logic cycle_end,
  input wire logic nop_cycle,
  input wire logic busy
);
  logic wr_i;
  logic first;
  logic pend2_reg;
  logic [3:0] bank_reg;
  logic [3:0] op;

  function automatic logic dwm(input logic [15:0] v);
    for (int i = 0; i < 4; i++) begin
      if ((v & ifd_pkg::DW_MASK[i]) == ifd_pkg::DW_MATCH[i]) return 1'b1;
    end
    return 1'b0;
  endfunction : dwm

  assign wr_i = psel && penable && pready && pwrite && paddr == ifd_pkg::OFS_INSTR;
  assign first = wr_i && !pend2_reg;
  assign op = pwdata[15:12];

  // A second word leaves the decode as it was, so only opening words are judged
  always_ff @(posedge clock) begin
    if (!nrst) pend2_reg <= 1'b0;
    else if (wr_i) pend2_reg <= first && dwm(pwdata[15:0]);
  end

  always_ff @(posedge clock) begin
    if (!nrst) bank_reg <= 4'h0;
    else if (psel && penable && pready && pwrite && paddr == ifd_pkg::OFS_BANK) bank_reg <= pwdata[3:0];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_first_dw;
    first && dwm(pwdata[15:0]);
  endsequence

  quarter_step_a: assert property (nrst && !wr_i |=> quarter == $past(quarter) + 2'h1)
    else $error("quarter did not advance");
  instr_restart_a: assert property (wr_i |=> quarter == 2'h0)
    else $error("quarter not restarted");
  cycle_end_a: assert property (nrst |=> cycle_end == ($past(quarter) == 2'h3 && !$past(wr_i)))
    else $error("cycle end misplaced");
  opcode_split_a: assert property (first |=> dec.opcode == $past(op))
    else $error("opcode field wrong");
  dest_sel_a: assert property (first && op inside {[4'h1:4'h6]} |=>
    dec.dest_working_register == !$past(pwdata[9])) else $error("destination select wrong");
  bank_sel_a: assert property (first && op inside {[4'h1:4'hB]} |=>
    dec.eff_addr == {($past(pwdata[8]) ? bank_reg : ACCESS_BANK), $past(pwdata[7:0])}) else $error("bank wrong");
  bit_field_a: assert property (first && op inside {[4'h7:4'hB]} |=>
    dec.bit_num == $past(pwdata[11:9]) && dec.cls == ifd_pkg::CLS_BIT) else $error("bit field wrong");
  lone_nop_a: assert property (first && op == 4'hF |=> dec.is_nop && !dec.double_word)
    else $error("lone second word not a no-op");
  double_word_a: assert property (s_first_dw |=> dec.double_word)
    else $error("double word not flagged");
  ptr_load_a: assert property (first && (pwdata[15:0] & ifd_pkg::PTR_MASK) == ifd_pkg::PTR_MATCH |=>
    dec.pointer_load && dec.pointer_sel == $past(pwdata[5:4])) else $error("pointer load wrong");
  ctl_mode_a: assert property (first && op inside {[4'hC:4'hE]} |=>
    dec.tbl_mode == $past(pwdata[1:0]) && dec.shadow == $past(pwdata[0])) else $error("control mode wrong");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  lone_nop_cycle_a: assert property (first && op == 4'hF |=> nop_cycle)
    else $error("lone second word cycle not a no-op");
  busy_start_a: assert property (first |=> busy)
    else $error("busy not raised on a new word");
  second_busy_a: assert property (pend2_reg && wr_i && op == 4'hF |=> busy)
    else $error("busy not raised after second word");
endmodule : ifd_decode_checker

bind ifd_decode ifd_decode_checker #(.ADDR_W(ADDR_W), .ACCESS_BANK(ACCESS_BANK)) u_chk (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dec(dec),
  .quarter(quarter), .cycle_end(cycle_end), .nop_cycle(nop_cycle), .busy(busy));

//--- verif/ifd_prog_mem.sv
`timescale 1ns/1ps
module ifd_prog_mem (
  // Fetch port
  input wire logic [3:0] idx,
  output logic [15:0] word
);
  logic [15:0] mem [0:10];
  // Last pair breaks the tag of its second word on purpose
  initial mem = '{16'h2600, 16'h2500, 16'h9E00, 16'h0F00, 16'hD100, 16'hEE20, 16'hF000,
    16'hF123, 16'hA300, 16'hEC00, 16'h1234};
  assign word = (idx <= 4'hA) ? mem[idx] : 16'hFFFF;
endmodule : ifd_prog_mem

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [3:0] AB = 4'h5;
  logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, cycle_end, nop_cycle, busy, dchk = 0, pend, dw;
  logic [1:0] quarter;
  logic [3:0] pc = 4'h0, bank;
  logic [15:0] w, word;
  ifd_pkg::ifd_dec_s dec, e, m;
  ifd_pkg::ifd_dec_s eq[$], mq[$];
  logic [32:0] rq[$], rm[$];
  int error_cnt = 0, samples_checked = 0;

  ifd_decode #(.ADDR_W(8), .ACCESS_BANK(AB)) u_dut (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dec(dec), .quarter(quarter), .cycle_end(cycle_end),
    .nop_cycle(nop_cycle), .busy(busy));
  ifd_prog_mem u_pm (.idx(pc), .word(word));

  always #2 clock = ~clock;

  task finish_test;
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [63:0] a, input logic [63:0] x, input logic [63:0] k);
    if (k != 64'h0) begin
      samples_checked++;
      if (((a ^ x) & k) !== 64'h0) begin
        $display("Error t=%0t got %h expected %h", $time, a & k, x & k);
        error_cnt++;
      end
    end
  endtask : cmp

  // Monitor: each answer takes the oldest note
  always @(posedge clock) begin
    dchk <= psel && penable && pready && pwrite && paddr == ifd_pkg::OFS_INSTR;
    if (psel && penable && pready && !pwrite)
      cmp(64'({pslverr, prdata}), 64'(rq.pop_front()), 64'(rm.pop_front()));
    if (dchk) cmp(64'(dec), 64'(eq.pop_front()), 64'(mq.pop_front()));
  end

  function automatic logic dwm(input logic [15:0] v);
    for (int i = 0; i < 4; i++) begin
      if ((v & ifd_pkg::DW_MASK[i]) == ifd_pkg::DW_MATCH[i]) return 1'b1;
    end
    return 1'b0;
  endfunction : dwm

  function automatic logic [1:0] cyc(input logic [15:0] v, input logic c);
    if (v[15:12] == 4'hF) return 2'h1;
    return (ifd_pkg::JUMP_MAP[v[15:12]] || (ifd_pkg::COND_MAP[v[15:12]] && c)) ? 2'h2 : 2'h1;
  endfunction : cyc

  function automatic void xd(input logic [15:0] v, output ifd_pkg::ifd_dec_s x, output ifd_pkg::ifd_dec_s k);
    logic [3:0] n;
    n = v[15:12];
    x = '0;
    k = '0;
    x.opcode = n;
    k.opcode = 4'hF;
    x.is_nop = n == 4'hF || v == ifd_pkg::NOP_WORD;
    k.is_nop = 1'b1;
    if (n == 4'hF) return;
    x.pointer_load = (v & ifd_pkg::PTR_MASK) == ifd_pkg::PTR_MATCH;
    x.cls = ifd_pkg::ifd_cls_e'(ifd_pkg::BIT_MAP[n] ? 4'h2 : (ifd_pkg::LIT_MAP[n] || x.pointer_load) ? 4'h4 :
      ifd_pkg::CTL_MAP[n] ? 4'h8 : 4'h1);
    k.cls = ifd_pkg::ifd_cls_e'(4'hF);
    x.double_word = dwm(v);
    k.double_word = 1'b1;
    k.pointer_load = 1'b1;
    x.pointer_sel = v[5:4];
    k.pointer_sel = {2{x.pointer_load}};
    x.file_addr = v[7:0];
    x.banked = v[8];
    x.eff_addr = {(v[8] ? bank : AB), v[7:0]};
    x.dest_working_register = !v[9];
    x.bit_num = v[11:9];
    x.literal = v[7:0];
    x.prog_addr = v[7:0];
    x.shadow = v[0];
    x.tbl_mode = ifd_pkg::ifd_tbl_e'(v[1:0]);
    if (n < 4'hC && n != 4'h0) begin
      k.file_addr = 8'hFF;
      k.banked = 1'b1;
      k.eff_addr = 12'hFFF;
    end
    k.dest_working_register = n < 4'h7 && n != 4'h0;
    k.bit_num = (x.cls == ifd_pkg::CLS_BIT) ? 3'h7 : 3'h0;
    k.literal = (x.cls == ifd_pkg::CLS_LIT) ? 8'hFF : 8'h00;
    if (x.cls == ifd_pkg::CLS_CTL) begin
      k.prog_addr = 8'hFF;
      k.shadow = 1'b1;
      k.tbl_mode = ifd_pkg::ifd_tbl_e'(2'h3);
    end
  endfunction : xd

  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] x, input logic [32:0] k);
    rq.push_back(x);
    rm.push_back(k);
    apb(a, 1'b0, 32'h0);
  endtask : rd

  task automatic idle();
    int n;
    n = 0;
    do begin
      rd(ifd_pkg::OFS_STAT, 33'h0, 33'h0);
      n++;
    end while (q[2:0] !== 3'h0 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      finish_test();
    end
  endtask : idle

  initial begin
    void'($urandom(32'h8A0FE050));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(ifd_pkg::OFS_CTRL, 33'h0, 33'h3);
    rd(ifd_pkg::OFS_BANK, 33'h0, 33'hF);
    rd(ifd_pkg::OFS_INFO, {17'h0, ifd_pkg::EXT_COUNT, ifd_pkg::STD_COUNT}, 33'hFFFF);
    rd(8'h1C, 33'h100000000, 33'h1FFFFFFFF);
    bank = 4'($urandom);
    apb(ifd_pkg::OFS_BANK, 1'b1, {28'h0, bank});
    rd(ifd_pkg::OFS_BANK, {29'h0, bank}, 33'hF);
    for (int c = 0; c < 2; c++) begin
      apb(ifd_pkg::OFS_CTRL, 1'b1, {30'h0, 1'b1, c[0]});
      rd(ifd_pkg::OFS_CTRL, {31'h0, 1'b1, c[0]}, 33'h3);
      pend = 1'b0;
      for (int i = 0; i < 11; i++) begin
        pc = i[3:0];
        @(posedge clock);
        w = word ^ {10'h0, 6'($urandom)};
        dw = !pend && dwm(w);
        xd(w, e, m);
        if (pend) m = '0;
        eq.push_back(e);
        mq.push_back(m);
        apb(ifd_pkg::OFS_INSTR, 1'b1, {16'h0, w});
        if (dw) rd(ifd_pkg::OFS_STAT, 33'h2, 33'h2);
        else begin
          idle();
          if (!pend) rd(ifd_pkg::OFS_STAT, {26'h0, cyc(w, c[0]), 5'h0}, 33'h70);
          else if (w[15:12] == 4'hF) rd(ifd_pkg::OFS_STAT, 33'h40, 33'h70);
          else rd(ifd_pkg::OFS_STAT, 33'h10, 33'h10);
        end
        pend = dw;
      end
      apb(ifd_pkg::OFS_STAT, 1'b1, 32'h4);
      rd(ifd_pkg::OFS_STAT, 33'h0, 33'h10);
    end
    repeat (10) @(posedge clock);
    finish_test();
  end
endmodule : tb_top
